//--- hdl/alu_result_unit.sv
// Combinational result, carry and zero for one operation
`timescale 1ns/1ps
`include "alu_defs.svh"

module alu_result_unit (
    alu_data_if.unit bus
);

    // Result per operation; carry held unless a shift
    always_comb begin
        bus.result    = bus.operand;
        bus.carry_new = bus.carry_old;                              // RL15
        case (bus.op)
            alu_pkg::increment_file_op: begin
                bus.result = bus.operand + `DATA_ONE;               // RL2
            end
            alu_pkg::or_accum_into_file_op: begin
                bus.result = bus.operand | bus.accum;               // RL3
            end
            alu_pkg::shift_left_logical_op: begin
                bus.result    = {bus.operand[`DATA_MSB-1:0], 1'b0}; // RL4
                bus.carry_new = bus.operand[`DATA_MSB];             // RL4
            end
            alu_pkg::shift_right_logical_op: begin
                bus.result    = {1'b0, bus.operand[`DATA_MSB:1]};   // RL5
                bus.carry_new = bus.operand[0];                     // RL5
            end
            alu_pkg::move_file_op: begin
                bus.result = bus.operand;                           // RL6
            end
            alu_pkg::indirect_load_to_accum_op: begin
                bus.result = bus.operand;                           // RL8
            end
            default: begin
                bus.result = bus.operand;
            end
        endcase
        // Zero follows the 8-bit result only
        bus.zero_new = (bus.result == `DATA_ZERO);                  // RL15
    end

endmodule : alu_result_unit

//--- hdl/file_alu_core.sv
// File-register ALU and indirect load datapath
// Behaviour
// RL1 - Destination bit picks accumulator or file register
// RL2 - Increment adds one, updates zero
// RL3 - OR accumulator with file, updates zero
// RL4 - Left shift: bit7 to carry, zero in
// RL5 - Right shift: bit0 to carry, zero in
// RL6 - Move copies value, zero reflects it
// RL7 - Move back to file leaves value, zero reflects it
// RL8 - Indirect load reads pointed location into accumulator
// RL9 - Update code picks pre/post increment/decrement
// RL10 - Offset form adds signed offset, pointer kept
// RL11 - Pointer ends plus one, minus one, or same
// RL12 - Window register redirects to pointed location
// RL13 - Pointer arithmetic wraps modulo 16 bits
// RL14 - Pointer stepping never touches status flags
// RL15 - Zero from result; carry kept unless shift
// RL16 - Each operation commits in one cycle
`timescale 1ns/1ps
`include "alu_defs.svh"

module file_alu_core #(
    parameter int DATA_AW = 8
) (
    // Clock and reset
    input  wire logic                   clk_in,
    input  wire logic                   resetn_in,
    // Operation request
    input  wire logic                   op_valid_in,
    input  wire logic [`OP_W-1:0]       op_code_in,
    input  wire logic [`FILE_AW-1:0]    file_addr_in,
    input  wire logic                   dest_in,
    input  wire logic                   ptr_sel_in,
    input  wire logic [`UPD_W-1:0]      pointer_update_code_in,
    input  wire logic                   offset_mode_in,
    input  wire logic [`OFS_W-1:0]      offset_in,
    // Direct loads from the rest of the core
    input  wire logic                   accum_load_in,
    input  wire logic [`DATA_W-1:0]     accum_data_in,
    input  wire logic                   ptr_load_in,
    input  wire logic                   ptr_load_sel_in,
    input  wire logic [`PTR_W-1:0]      ptr_load_data_in,
    input  wire logic                   mem_wr_in,
    input  wire logic [DATA_AW-1:0]     mem_wr_addr_in,
    input  wire logic [`DATA_W-1:0]     mem_wr_data_in,
    input  wire logic [DATA_AW-1:0]     peek_addr_in,
    // State visible to the core
    output logic [`DATA_W-1:0]          accum_out,
    output logic                        carry_out,
    output logic                        zero_out,
    output logic [`PTR_W-1:0]           ptr0_out,
    output logic [`PTR_W-1:0]           ptr1_out,
    output logic                        done_out,
    output logic [`DATA_W-1:0]          peek_data_out
);

    localparam int DEPTH = 1 << DATA_AW;

    // Data space; pointer addresses fold onto it by their low bits
    logic [`DATA_W-1:0]     mem_r [DEPTH];

    alu_pkg::alu_state_t    state_r;
    alu_pkg::alu_state_t    state_nxt;

    alu_data_if             dbus ();

    alu_pkg::alu_op_t       op;
    logic                   is_indirect;
    logic [`PTR_W-1:0]      ptr_cur;
    logic [`PTR_W-1:0]      ptr_inc;
    logic [`PTR_W-1:0]      ptr_dec;
    logic [`PTR_W-1:0]      ptr_ofs;
    logic [`PTR_W-1:0]      ind_addr;
    logic [`PTR_W-1:0]      ptr_after;
    logic [`PTR_W-1:0]      file_addr;
    logic [`PTR_W-1:0]      eff_addr;
    logic                   mem_we;
    logic [DATA_AW-1:0]     mem_wa;
    logic [`DATA_W-1:0]     mem_wd;

    assign op          = alu_pkg::alu_op_t'(op_code_in);
    assign is_indirect = (op == alu_pkg::indirect_load_to_accum_op);

    // Pointer candidates; 16-bit sums drop the carry so they wrap
    always_comb begin
        ptr_cur = ptr_sel_in ? state_r.ptr1 : state_r.ptr0;
        ptr_inc = ptr_cur + `PTR_ONE;                                        // RL13
        ptr_dec = ptr_cur - `PTR_ONE;                                        // RL13
        ptr_ofs = ptr_cur + {{(`PTR_W-`OFS_W){offset_in[`OFS_W-1]}}, offset_in}; // RL10
    end

    // Indirect address and pointer afterwards
    always_comb begin
        ind_addr  = ptr_cur;
        ptr_after = ptr_cur;
        if (offset_mode_in) begin
            ind_addr  = ptr_ofs;                                             // RL10
            ptr_after = ptr_cur;                                             // RL11
        end else begin
            case (pointer_update_code_in)
                `UPD_PRE_INC: begin
                    ind_addr  = ptr_inc;                                     // RL9
                    ptr_after = ptr_inc;                                     // RL11
                end
                `UPD_PRE_DEC: begin
                    ind_addr  = ptr_dec;                                     // RL9
                    ptr_after = ptr_dec;                                     // RL11
                end
                `UPD_POST_INC: begin
                    ind_addr  = ptr_cur;                                     // RL9
                    ptr_after = ptr_inc;                                     // RL11
                end
                `UPD_POST_DEC: begin
                    ind_addr  = ptr_cur;                                     // RL9
                    ptr_after = ptr_dec;                                     // RL11
                end
                default: begin
                    ind_addr  = ptr_cur;
                    ptr_after = ptr_cur;
                end
            endcase
        end
    end

    // Window addresses own no storage; they alias the pointed location
    always_comb begin
        file_addr = {{(`PTR_W-`FILE_AW){1'b0}}, file_addr_in};
        if (file_addr_in == `WINDOW0_ADDR) begin
            file_addr = state_r.ptr0;                                        // RL12
        end else if (file_addr_in == `WINDOW1_ADDR) begin
            file_addr = state_r.ptr1;                                        // RL12
        end
        eff_addr = is_indirect ? ind_addr : file_addr;                       // RL8
    end

    // Operands to the result unit
    always_comb begin
        dbus.op        = op;
        dbus.operand   = mem_r[eff_addr[DATA_AW-1:0]];
        dbus.accum     = state_r.accum;
        dbus.carry_old = state_r.carry;
    end

    alu_result_unit u_result (
        .bus (dbus.unit)
    );

    // Next state: operation first, then direct loads when idle
    always_comb begin
        state_nxt           = state_r;
        state_nxt.done      = 1'b0;
        state_nxt.peek_data = mem_r[peek_addr_in];
        mem_we              = 1'b0;
        mem_wa              = mem_wr_addr_in;
        mem_wd              = mem_wr_data_in;
        if (op_valid_in) begin
            // Result, flags and pointer all commit on this edge
            state_nxt.done  = 1'b1;                                          // RL16
            state_nxt.zero  = dbus.zero_new;                                 // RL15
            state_nxt.carry = dbus.carry_new;                                // RL15
            if (is_indirect) begin
                state_nxt.accum = dbus.result;                               // RL8
                // Pointer step leaves the flags to the moved data
                if (ptr_sel_in) begin
                    state_nxt.ptr1 = ptr_after;                              // RL14
                end else begin
                    state_nxt.ptr0 = ptr_after;                              // RL14
                end
            end else if (dest_in == `DEST_ACCUM) begin
                state_nxt.accum = dbus.result;                               // RL1
            end else begin
                // A move writes back the value it read, so it stays put
                mem_we = 1'b1;                                               // RL1 RL7
                mem_wa = eff_addr[DATA_AW-1:0];
                mem_wd = dbus.result;
            end
        end else begin
            mem_we = mem_wr_in;
            if (accum_load_in) begin
                state_nxt.accum = accum_data_in;
            end
            if (ptr_load_in && ptr_load_sel_in) begin
                state_nxt.ptr1 = ptr_load_data_in;
            end
            if (ptr_load_in && !ptr_load_sel_in) begin
                state_nxt.ptr0 = ptr_load_data_in;
            end
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= '{accum:     `ACCUM_RST,
                         carry:     1'b0,
                         zero:      1'b0,
                         ptr0:      `PTR_RST,
                         ptr1:      `PTR_RST,
                         done:      1'b0,
                         peek_data: `DATA_ZERO};
        end else begin
            state_r <= state_nxt;
        end
    end

    // Data storage; no reset, contents are software's business
    always_ff @(posedge clk_in) begin
        if (mem_we) begin
            mem_r[mem_wa] <= mem_wd;
        end
    end

    // Outputs straight from the state register
    assign accum_out     = state_r.accum;
    assign carry_out     = state_r.carry;
    assign zero_out      = state_r.zero;
    assign ptr0_out      = state_r.ptr0;
    assign ptr1_out      = state_r.ptr1;
    assign done_out      = state_r.done;
    assign peek_data_out = state_r.peek_data;

endmodule : file_alu_core

//--- pkg/alu_data_if.sv
// Operand and result bundle between datapath control and result unit
`timescale 1ns/1ps
`include "alu_defs.svh"

interface alu_data_if;
    alu_pkg::alu_op_t        op;
    logic [`DATA_W-1:0]      operand;
    logic [`DATA_W-1:0]      accum;
    logic                    carry_old;
    logic [`DATA_W-1:0]      result;
    logic                    carry_new;
    logic                    zero_new;

    modport ctrl (output op, output operand, output accum, output carry_old,
                  input result, input carry_new, input zero_new);
    modport unit (input op, input operand, input accum, input carry_old,
                  output result, output carry_new, output zero_new);
endinterface : alu_data_if

//--- pkg/alu_defs.svh
// Constants for the file-register datapath
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH

`define DATA_W          8
`define PTR_W           16
`define FILE_AW         7
`define OFS_W           6
`define OP_W            3
`define UPD_W           2
`define WINDOW0_ADDR    7'h00
`define WINDOW1_ADDR    7'h01
`define UPD_PRE_INC     2'h0
`define UPD_PRE_DEC     2'h1
`define UPD_POST_INC    2'h2
`define UPD_POST_DEC    2'h3
`define ACCUM_RST       8'h00
`define PTR_RST         16'h0000
`define PTR_ONE         16'h0001
`define DATA_ONE        8'h01
`define DATA_ZERO       8'h00
`define DATA_MSB        7
`define DEST_ACCUM      1'b0
`define DEST_FILE       1'b1

`endif

//--- pkg/alu_pkg.sv
// Types shared by the file-register datapath modules
package alu_pkg;

    // Operation selector
    typedef enum logic [2:0] {
        increment_file_op         = 3'h0,
        or_accum_into_file_op     = 3'h1,
        shift_left_logical_op     = 3'h2,
        shift_right_logical_op    = 3'h3,
        move_file_op              = 3'h4,
        indirect_load_to_accum_op = 3'h5
    } alu_op_t;

    // Architectural state of the datapath
    typedef struct packed {
        logic [7:0]  accum;
        logic        carry;
        logic        zero;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic        done;
        logic [7:0]  peek_data;
    } alu_state_t;

endpackage : alu_pkg

//--- testbench/file_alu_props.sv
// Concurrent checks on the datapath top ports
`timescale 1ns/1ps
`include "alu_defs.svh"

module file_alu_props #(
    parameter int DATA_AW = 8
) (
    // Clock, reset and request
    input wire logic              clk_in,
    input wire logic              resetn_in,
    input wire logic              op_valid_in,
    input wire logic [`OP_W-1:0]  op_code_in,
    input wire logic              dest_in,
    input wire logic              ptr_sel_in,
    input wire logic [`UPD_W-1:0] pointer_update_code_in,
    input wire logic              offset_mode_in,
    // Visible state
    input wire logic [7:0]        accum_out,
    input wire logic              carry_out,
    input wire logic              zero_out,
    input wire logic [15:0]       ptr0_out,
    input wire logic [15:0]       ptr1_out,
    input wire logic              done_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    // Decoded request kinds
    wire ind  = op_valid_in && op_code_in == 3'h5;
    wire step = ind && !offset_mode_in;

    // Step of -1 is added as all ones so the sum wraps in 16 bits
    a_done_after_op: assert property (op_valid_in |=> done_out)
        else $error("done missing");
    a_zero_from_accum: assert property (op_valid_in && (!dest_in || ind) |=>
        zero_out == (accum_out == 8'h00)) else $error("zero wrong");
    a_file_keeps_accum: assert property (op_valid_in && dest_in && !ind |=>
        $stable(accum_out)) else $error("accum changed");
    a_carry_kept: assert property (op_valid_in && op_code_in != 3'h2 &&
        op_code_in != 3'h3 |=> $stable(carry_out)) else $error("carry changed");
    a_offset_keeps_ptr: assert property (ind && offset_mode_in |=>
        $stable(ptr0_out) && $stable(ptr1_out)) else $error("ptr moved");
    a_ptr0_steps: assert property (step && !ptr_sel_in |=> $stable(ptr1_out) &&
        ptr0_out == $past(ptr0_out) + ($past(pointer_update_code_in[0]) ? 16'hffff :
        16'h0001)) else $error("ptr0 step wrong");
    a_ptr1_steps: assert property (step && ptr_sel_in |=> $stable(ptr0_out) &&
        ptr1_out == $past(ptr1_out) + ($past(pointer_update_code_in[0]) ? 16'hffff :
        16'h0001)) else $error("ptr1 step wrong");
    a_shl_zero_in: assert property (op_valid_in && op_code_in == 3'h2 && !dest_in
        |=> !accum_out[0]) else $error("shift lsb not zero");

    c_step: cover property (step);
    c_offset: cover property (ind && offset_mode_in);
    c_shift: cover property (op_valid_in && op_code_in == 3'h3);
endmodule : file_alu_props

bind file_alu_core file_alu_props #(.DATA_AW(DATA_AW)) u_props (.clk_in, .resetn_in,
    .op_valid_in, .op_code_in, .dest_in, .ptr_sel_in, .pointer_update_code_in,
    .offset_mode_in, .accum_out, .carry_out, .zero_out, .ptr0_out, .ptr1_out, .done_out);

//--- testbench/test_file_alu_core.sv
// Directed bench for the file-register datapath
`timescale 1ns/1ps

module test_file_alu_core;
    logic        clk_in, resetn_in, op_valid_in, dest_in, ptr_sel_in, offset_mode_in;
    logic        accum_load_in, ptr_load_in, ptr_load_sel_in, mem_wr_in;
    logic        carry_out, zero_out, done_out;
    logic [1:0]  pointer_update_code_in;
    logic [2:0]  op_code_in;
    logic [5:0]  offset_in;
    logic [6:0]  file_addr_in;
    logic [7:0]  accum_data_in, mem_wr_addr_in, mem_wr_data_in, peek_addr_in;
    logic [7:0]  accum_out, peek_data_out;
    logic [15:0] ptr_load_data_in, ptr0_out, ptr1_out;
    int          n_errors = 0;
    int          n_checks = 0;

    file_alu_core #(.DATA_AW(8)) dut (
        .clk_in, .resetn_in, .op_valid_in, .op_code_in, .file_addr_in, .dest_in,
        .ptr_sel_in, .pointer_update_code_in, .offset_mode_in, .offset_in,
        .accum_load_in, .accum_data_in, .ptr_load_in, .ptr_load_sel_in, .ptr_load_data_in,
        .mem_wr_in, .mem_wr_addr_in, .mem_wr_data_in, .peek_addr_in,
        .accum_out, .carry_out, .zero_out, .ptr0_out, .ptr1_out, .done_out, .peek_data_out
    );

    // Free-running 200 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One strobe for one edge, then an idle cycle so strobes never merge
    task automatic pulse(input int k);
        case (k)
            0: op_valid_in = 1'b1;
            1: accum_load_in = 1'b1;
            2: ptr_load_in = 1'b1;
            default: mem_wr_in = 1'b1;
        endcase
        @(negedge clk_in);
        chk("done", k == 0, done_out);
        {op_valid_in, accum_load_in, ptr_load_in, mem_wr_in} = 4'h0;
        @(negedge clk_in);
    endtask : pulse

    task automatic wm(input logic [7:0] a, input logic [7:0] d);
        mem_wr_addr_in = a;
        mem_wr_data_in = d;
        pulse(3);
    endtask : wm

    task automatic wp(input logic s, input logic [15:0] d);
        ptr_load_sel_in = s;
        ptr_load_data_in = d;
        pulse(2);
    endtask : wp

    task automatic op(input logic [2:0] c, input logic [6:0] a, input logic d);
        op_code_in = c;
        file_addr_in = a;
        dest_in = d;
        pulse(0);
    endtask : op

    task automatic ind(input logic s, input logic [1:0] u, input logic m, input logic [5:0] o);
        ptr_sel_in = s;
        pointer_update_code_in = u;
        offset_mode_in = m;
        offset_in = o;
        op(3'h5, 7'h00, 1'b0);
    endtask : ind

    task automatic res(input logic [7:0] a, input logic c, input logic z);
        chk("accum", a, accum_out);
        chk("carry", c, carry_out);
        chk("zero", z, zero_out);
    endtask : res

    // Peek data lags its address by one edge
    task automatic pk(input logic [7:0] a, input logic [7:0] e);
        peek_addr_in = a;
        @(negedge clk_in);
        chk("peek", e, peek_data_out);
    endtask : pk

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    // Hang guard, far beyond the roughly one hundred cycles the tests take
    initial begin
        repeat (3000) @(posedge clk_in);
        n_errors++;
        end_of_test();
    end

    initial begin
        logic [15:0] e;
        {op_valid_in, dest_in, ptr_sel_in, offset_mode_in, accum_load_in, ptr_load_in} = '0;
        {ptr_load_sel_in, mem_wr_in, pointer_update_code_in, op_code_in, offset_in} = '0;
        {file_addr_in, accum_data_in, mem_wr_addr_in, mem_wr_data_in, peek_addr_in} = '0;
        ptr_load_data_in = '0;
        resetn_in = 1'b0;
        repeat (4) @(negedge clk_in);
        resetn_in = 1'b1;
        res(8'h00, 1'b0, 1'b0);
        chk("ptr0", 16'h0000, ptr0_out);
        wm(8'h05, 8'hff);
        op(3'h0, 7'h05, 1'b0);
        res(8'h00, 1'b0, 1'b1);
        accum_data_in = 8'h3c;
        pulse(1);
        op(3'h0, 7'h05, 1'b1);
        res(8'h3c, 1'b0, 1'b1);
        pk(8'h05, 8'h00);
        wm(8'h06, 8'h41);
        op(3'h1, 7'h06, 1'b0);
        res(8'h7d, 1'b0, 1'b0);
        wm(8'h08, 8'h81);
        op(3'h2, 7'h08, 1'b0);
        res(8'h02, 1'b1, 1'b0);
        wm(8'h09, 8'h01);
        op(3'h3, 7'h09, 1'b1);
        res(8'h02, 1'b1, 1'b1);
        pk(8'h09, 8'h00);
        wm(8'h0a, 8'h80);
        op(3'h3, 7'h0a, 1'b0);
        res(8'h40, 1'b0, 1'b0);
        wm(8'h0b, 8'h00);
        op(3'h4, 7'h0b, 1'b1);
        res(8'h40, 1'b0, 1'b1);
        pk(8'h0b, 8'h00);
        wm(8'h0c, 8'h5a);
        // Nonzero move back: value kept, zero cleared by it
        op(3'h4, 7'h0c, 1'b1);
        res(8'h40, 1'b0, 1'b0);
        pk(8'h0c, 8'h5a);
        op(3'h4, 7'h0c, 1'b0);
        res(8'h5a, 1'b0, 1'b0);
        wm(8'h0f, 8'ha1);
        wm(8'h10, 8'ha2);
        wm(8'h11, 8'ha3);
        // Every update code from the same start pointer
        for (int u = 0; u < 4; u++) begin
            wp(1'b0, 16'h0010);
            ind(1'b0, u[1:0], 1'b0, 6'h00);
            e = u[1] ? 16'h0010 : (u[0] ? 16'h000f : 16'h0011);
            res(8'ha2 + e[7:0] - 8'h10, 1'b0, 1'b0);
            chk("ptr0", u[0] ? 16'h000f : 16'h0011, ptr0_out);
        end
        wp(1'b1, 16'h0010);
        ind(1'b1, 2'h0, 1'b1, 6'h3f);
        res(8'ha1, 1'b0, 1'b0);
        chk("ptr1", 16'h0010, ptr1_out);
        wm(8'h2f, 8'h00);
        ind(1'b1, 2'h2, 1'b1, 6'h1f);
        res(8'h00, 1'b0, 1'b1);
        wm(8'hff, 8'h66);
        // Carry set first, so a pointer step that disturbed it would show
        op(3'h2, 7'h08, 1'b0);
        res(8'h02, 1'b1, 1'b0);
        wp(1'b0, 16'hffff);
        ind(1'b0, 2'h2, 1'b0, 6'h00);
        res(8'h66, 1'b1, 1'b0);
        chk("ptr0", 16'h0000, ptr0_out);
        wp(1'b1, 16'h0000);
        ind(1'b1, 2'h1, 1'b0, 6'h00);
        chk("ptr1", 16'hffff, ptr1_out);
        wp(1'b0, 16'h0030);
        wm(8'h30, 8'h77);
        op(3'h4, 7'h00, 1'b0);
        res(8'h77, 1'b1, 1'b0);
        op(3'h0, 7'h00, 1'b1);
        pk(8'h30, 8'h78);
        op(3'h4, 7'h01, 1'b0);
        res(8'h66, 1'b1, 1'b0);
        end_of_test();
    end
endmodule : test_file_alu_core
